// ---- logic/asu_pkg.sv ----
package asu_pkg;
  // register byte offsets (word aligned)
  localparam logic [7:0] STATUS_OFS   = 8'h00;
  localparam logic [7:0] DATA_OFS     = 8'h04;
  localparam logic [7:0] CTRL_ONE_OFS = 8'h08;
  localparam logic [7:0] CTRL_TWO_OFS = 8'h0c;
  localparam logic [7:0] DIVIDER_OFS  = 8'h10;
  // reset values
  localparam logic [7:0]  STATUS_RST  = 8'hc0;
  localparam logic [7:0]  CTRL_RST    = 8'h00;
  localparam logic [15:0] DIVIDER_RST = 16'h001a;
  // status bit positions
  localparam int ST_TXE = 7;
  localparam int ST_TXD = 6;
  localparam int ST_RXF = 5;
  localparam int ST_IDL = 4;
  localparam int ST_OVR = 3;
  localparam int ST_NSE = 2;
  localparam int ST_FRM = 1;
  localparam int ST_PAR = 0;
  // ctrl one bit positions
  localparam int C1_WLEN = 4;
  localparam int C1_WAKE = 3;
  localparam int C1_PEN  = 2;
  localparam int C1_PODD = 1;
  localparam int C1_PIE  = 0;
  // ctrl two bit positions
  localparam int C2_TIE  = 7;
  localparam int C2_TX_DONE_IRQ_EN = 6;
  localparam int C2_RIE  = 5;
  localparam int C2_LINE_QUIET_IRQ_EN = 4;
  localparam int C2_TE   = 3;
  localparam int C2_RE   = 2;
  localparam int C2_MUTE = 1;
  // oversampling
  localparam logic [3:0] SAMPLES_PER_BIT = 4'hf;
  localparam logic [3:0] SMP_8  = 4'h7;
  localparam logic [3:0] SMP_9  = 4'h8;
  localparam logic [3:0] SMP_10 = 4'h9;

  typedef enum logic [2:0] {
    ASU_IDLE  = 3'b001,
    ASU_START = 3'b010,
    ASU_DATA  = 3'b100
  } asu_rx_e;

  typedef struct packed {
    logic       wlen;
    logic       wake;
    logic       pen;
    logic       podd;
    logic       parity_fail_irq_en;
  } asu_cfg_s;
endpackage : asu_pkg

// ---- logic/asu_core.sv ----
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
// Operation
// - mute blocks receive flags and interrupts
// - wake by idle or address mark
// - idle wake clears mute, no idle flag
// - address mark wakes and receives word
// - frame start, 8 or 9 bits, stop
// - address mark uses data msb
// - even parity when odd select clear
// - odd parity when odd select set
// - transmitter replaces msb with parity
// - parity failure sets flag and interrupt
// - sixteen samples, majority of 8-10
// - unequal data samples set noise
// - sampling phase resynced each start bit
// - pin sampled on sample tick edge
// - start edge and samples 3,5,7 checked
// - start samples 8-10 high set noise
// - enabled requests exit wait
// - halt freezes unit, no halt wake (receiver is forced back to idle, not frozen)
// - all events on one request line
// - each event gated by its enable
// - status read only, resets to c0
// - mute set by software, cleared by hardware
// - status read then data read clears
// - rx enable covers overrun and full
module asu_core (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        rx_pin_i,
  input  wire logic        halt_i,
  input  wire logic        tx_busy_i,
  input  wire logic        tx_done_i,
  output logic      [8:0]  tx_word_o,
  output logic             tx_load_o,
  output logic             irq_o,
  output logic             wait_exit_o
);
  logic [7:0]  status_reg;
  logic [7:0]  ctrl_one_reg;
  logic [7:0]  ctrl_two_reg;
  logic [15:0] divider_reg;
  logic [8:0]  rx_data_reg;
  logic        status_seen_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic [8:0]  tx_word_reg;
  logic        tx_load_reg;
  logic        irq_reg;
  logic        wait_exit_reg;
  logic        rx_meta_reg;
  logic        rx_sync_reg;
  logic [15:0] tick_cnt_reg;
  logic        tick_reg;
  logic [3:0]  smp_cnt_reg;
  logic [3:0]  bit_cnt_reg;
  logic [2:0]  smp_vote_reg;
  logic [2:0]  hist_reg;
  logic        edge_ok_reg;
  logic        noise_pend_reg;
  logic [9:0]  shift_reg;
  logic [3:0]  idle_cnt_reg;
  asu_pkg::asu_rx_e rx_state_reg;
  default clocking cb_asu @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  function automatic logic majority(input logic [2:0] v);
    majority = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction : majority

  function automatic logic parity_of(input logic [7:0] d, input logic wlen, input logic odd);
    logic p;
    p = ^d[6:0];
    if (wlen) begin
      p = p ^ d[7];
    end
    parity_of = p ^ odd;
  endfunction : parity_of

  // bus decode
  wire bus_acc   = psel_i & penable_i & ~pready_reg;
  wire wr_acc    = bus_acc & pwrite_i;
  wire rd_acc    = bus_acc & ~pwrite_i;
  wire hit_st    = paddr_i == asu_pkg::STATUS_OFS;
  wire hit_dat   = paddr_i == asu_pkg::DATA_OFS;
  wire hit_c1    = paddr_i == asu_pkg::CTRL_ONE_OFS;
  wire hit_c2    = paddr_i == asu_pkg::CTRL_TWO_OFS;
  wire hit_div   = paddr_i == asu_pkg::DIVIDER_OFS;
  wire mapped    = hit_st | hit_dat | hit_c1 | hit_c2 | hit_div;
  wire wr_dat    = wr_acc & hit_dat;
  wire rd_st     = rd_acc & hit_st;
  wire rd_dat    = rd_acc & hit_dat;
  wire rx_clear  = rd_dat & status_seen_reg;
  wire tx_clear  = wr_dat & status_seen_reg;
  // status and tick counter frozen in halt; receiver forced to idle, bus writes still land
  wire run       = ~halt_i;
  wire muted     = ctrl_two_reg[asu_pkg::C2_MUTE];
  wire rx_en     = ctrl_two_reg[asu_pkg::C2_RE] & run;
  asu_pkg::asu_cfg_s cfg;
  assign cfg = '{wlen: ctrl_one_reg[asu_pkg::C1_WLEN], wake: ctrl_one_reg[asu_pkg::C1_WAKE],
                 pen: ctrl_one_reg[asu_pkg::C1_PEN], podd: ctrl_one_reg[asu_pkg::C1_PODD],
                 parity_fail_irq_en: ctrl_one_reg[asu_pkg::C1_PIE]};

  // receive sampling
  wire [3:0] last_bit  = cfg.wlen ? 4'h9 : 4'h8;
  wire       bit_end   = tick_reg & run & (smp_cnt_reg == asu_pkg::SAMPLES_PER_BIT);
  wire       smp_bit   = majority(smp_vote_reg);
  wire       smp_noisy = (smp_vote_reg != 3'b000) & (smp_vote_reg != 3'b111);
  wire       fall      = rx_state_reg == asu_pkg::ASU_IDLE & tick_reg & ~rx_sync_reg;
  wire       start_bad = smp_vote_reg != 3'b000;
  wire       frame_end = rx_state_reg == asu_pkg::ASU_DATA & bit_end & (bit_cnt_reg == last_bit);
  wire [8:0] word      = cfg.wlen ? shift_reg[9:1] : {1'b0, shift_reg[9:2]};
  // stop bit is not shifted in yet at frame end, its vote is still live
  wire       stop_ok   = smp_bit;
  wire       word_msb  = cfg.wlen ? word[8] : word[7];
  wire       par_bad   = cfg.pen &
                         (parity_of(word[7:0], cfg.wlen, cfg.podd) != word_msb);
  wire       addr_wake = muted & cfg.wake & word_msb;
  wire       accept    = frame_end & (~muted | addr_wake);
  wire       idle_seen = idle_cnt_reg == last_bit + 4'h1;
  wire       idle_evt  = tick_reg & bit_end & rx_state_reg == asu_pkg::ASU_IDLE & idle_seen;
  wire       idle_wake = idle_evt & muted & ~cfg.wake;
  wire       hw_unmute = idle_wake | (frame_end & addr_wake);
  wire       full_now  = status_reg[asu_pkg::ST_RXF];

  // interrupt gating
  wire [4:0] req_vec = {status_reg[asu_pkg::ST_TXE] & ctrl_two_reg[asu_pkg::C2_TIE],
                        status_reg[asu_pkg::ST_TXD] & ctrl_two_reg[asu_pkg::C2_TX_DONE_IRQ_EN],
                        (full_now | status_reg[asu_pkg::ST_OVR]) &
                          ctrl_two_reg[asu_pkg::C2_RIE],
                        status_reg[asu_pkg::ST_IDL] & ctrl_two_reg[asu_pkg::C2_LINE_QUIET_IRQ_EN],
                        status_reg[asu_pkg::ST_PAR] & cfg.parity_fail_irq_en};
  wire       rx_reqs = |req_vec[2:0];
  wire       irq_next = run & ((|req_vec[4:3]) | (~muted & rx_reqs));

  // status next value; hardware set wins over software clear
  logic [7:0] status_next;
  always_comb begin
    status_next = status_reg;
    if (rx_clear) begin
      status_next[5:0] = 6'h00;
    end
    if (tx_clear) begin
      status_next[asu_pkg::ST_TXE] = 1'b0;
      status_next[asu_pkg::ST_TXD] = 1'b0;
    end
    if (~tx_busy_i & ~tx_load_reg) begin
      status_next[asu_pkg::ST_TXE] = 1'b1;
    end
    if (tx_done_i) begin
      status_next[asu_pkg::ST_TXD] = 1'b1;
    end
    if (accept) begin
      if (full_now & ~rx_clear) begin
        status_next[asu_pkg::ST_OVR] = 1'b1;
      end else begin
        status_next[asu_pkg::ST_RXF] = 1'b1;
        status_next[asu_pkg::ST_NSE] = noise_pend_reg | status_next[asu_pkg::ST_NSE];
        status_next[asu_pkg::ST_FRM] = ~stop_ok | status_next[asu_pkg::ST_FRM];
        status_next[asu_pkg::ST_PAR] = par_bad | status_next[asu_pkg::ST_PAR];
      end
    end
    if (idle_evt & ~muted) begin
      status_next[asu_pkg::ST_IDL] = 1'b1;
    end
  end

  // receive pin synchroniser
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
    end else begin
      rx_meta_reg <= rx_pin_i;
      rx_sync_reg <= rx_meta_reg;
    end
  end

  // sample tick from divider; the pin is read on this strobe, not on each clock
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tick_cnt_reg <= 16'h0000;
      tick_reg     <= 1'b0;
    end else if (run & (tick_cnt_reg >= divider_reg)) begin
      tick_cnt_reg <= 16'h0000;
      tick_reg     <= 1'b1;
    end else begin
      tick_cnt_reg <= run ? tick_cnt_reg + 16'h0001 : tick_cnt_reg;
      tick_reg     <= 1'b0;
    end
  end

  // receive state machine
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rx_state_reg   <= asu_pkg::ASU_IDLE;
      smp_cnt_reg    <= 4'h0;
      bit_cnt_reg    <= 4'h0;
      smp_vote_reg   <= 3'b111;
      hist_reg       <= 3'b111;  // idle level, so no false edge after reset
      edge_ok_reg    <= 1'b0;
      noise_pend_reg <= 1'b0;
      shift_reg      <= 10'h000;
      idle_cnt_reg   <= 4'h0;
    end else if (~rx_en) begin
      rx_state_reg <= asu_pkg::ASU_IDLE;
      smp_cnt_reg  <= 4'h0;
    end else if (tick_reg) begin
      smp_cnt_reg <= smp_cnt_reg + 4'h1;
      // history runs in every state so stop bit samples count before the next edge
      hist_reg    <= {hist_reg[1:0], rx_sync_reg};
      if (smp_cnt_reg == asu_pkg::SMP_8) begin
        smp_vote_reg[0] <= rx_sync_reg;
      end
      if (smp_cnt_reg == asu_pkg::SMP_9) begin
        smp_vote_reg[1] <= rx_sync_reg;
      end
      if (smp_cnt_reg == asu_pkg::SMP_10) begin
        smp_vote_reg[2] <= rx_sync_reg;
      end
      case (rx_state_reg)
        asu_pkg::ASU_IDLE: begin
          if (bit_end) begin
            idle_cnt_reg <= idle_seen ? 4'h0 : idle_cnt_reg + 4'h1;
          end
          if (fall) begin
            rx_state_reg <= asu_pkg::ASU_START;
            smp_cnt_reg  <= 4'h1;
            idle_cnt_reg <= 4'h0;
            edge_ok_reg  <= hist_reg == 3'b111;
          end
        end
        asu_pkg::ASU_START: begin
          if ((smp_cnt_reg == 4'h2 | smp_cnt_reg == 4'h4 | smp_cnt_reg == 4'h6) & rx_sync_reg) begin
            edge_ok_reg <= 1'b0;
          end
          if (bit_end) begin
            noise_pend_reg <= noise_pend_reg | ~edge_ok_reg | start_bad;
            bit_cnt_reg    <= 4'h0;
            rx_state_reg   <= majority(smp_vote_reg) ? asu_pkg::ASU_IDLE : asu_pkg::ASU_DATA;
          end
        end
        asu_pkg::ASU_DATA: begin
          if (bit_end) begin
            shift_reg      <= {smp_bit, shift_reg[9:1]};
            noise_pend_reg <= noise_pend_reg | smp_noisy;
            bit_cnt_reg    <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == last_bit) begin
              rx_state_reg <= asu_pkg::ASU_IDLE;
            end
          end
          if (frame_end & accept) begin
            noise_pend_reg <= 1'b0;
          end
        end
        default: rx_state_reg <= asu_pkg::ASU_IDLE;
      endcase
    end
  end

  // register file and bus answer, one wait state per access
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      status_reg      <= asu_pkg::STATUS_RST;
      ctrl_one_reg    <= asu_pkg::CTRL_RST;
      ctrl_two_reg    <= asu_pkg::CTRL_RST;
      divider_reg     <= asu_pkg::DIVIDER_RST;
      rx_data_reg     <= 9'h000;
      status_seen_reg <= 1'b0;
      prdata_reg      <= 32'h00000000;
      pready_reg      <= 1'b0;
      pslverr_reg     <= 1'b0;
      tx_word_reg     <= 9'h000;
      tx_load_reg     <= 1'b0;
      irq_reg         <= 1'b0;
      wait_exit_reg   <= 1'b0;
    end else begin
      pready_reg    <= bus_acc;
      pslverr_reg   <= bus_acc & ~mapped;
      irq_reg       <= irq_next;
      wait_exit_reg <= irq_next;
      tx_load_reg   <= wr_dat & run;
      if (run) begin
        status_reg <= status_next;
      end
      if (accept & ~(full_now & ~rx_clear)) begin
        rx_data_reg <= word;
      end
      if (rd_st) begin
        status_seen_reg <= 1'b1;
      end else if (rd_dat | wr_dat) begin
        status_seen_reg <= 1'b0;
      end
      if (wr_dat) begin
        tx_word_reg <= pwdata_i[8:0];
        if (cfg.pen) begin
          if (cfg.wlen) begin
            tx_word_reg[8] <= parity_of(pwdata_i[7:0], 1'b1, cfg.podd);
          end else begin
            tx_word_reg[7] <= parity_of(pwdata_i[7:0], 1'b0, cfg.podd);
          end
        end
      end
      if (wr_acc & hit_c1) begin
        ctrl_one_reg <= {3'b000, pwdata_i[4:0]};
      end
      if (wr_acc & hit_div) begin
        divider_reg <= pwdata_i[15:0];
      end
      // a write while muted can re-mute after an address wake
      if (wr_acc & hit_c2) begin
        ctrl_two_reg <= pwdata_i[7:0] & 8'hfe;
      end else if (hw_unmute & run) begin
        ctrl_two_reg[asu_pkg::C2_MUTE] <= 1'b0;
      end
      if (rd_acc) begin
        prdata_reg <= hit_st  ? {24'h000000, status_reg} :
                      hit_dat ? {23'h000000, rx_data_reg} :
                      hit_c1  ? {24'h000000, rx_data_reg[8], ctrl_one_reg[6:0]} :
                      hit_c2  ? {24'h000000, ctrl_two_reg} :
                      hit_div ? {16'h0000, divider_reg} : 32'h00000000;
      end
    end
  end

  assign prdata_o    = prdata_reg;
  assign pready_o    = pready_reg;
  assign pslverr_o   = pslverr_reg;
  assign tx_word_o   = tx_word_reg;
  assign tx_load_o   = tx_load_reg;
  assign irq_o       = irq_reg;
  assign wait_exit_o = wait_exit_reg;

  property p_mute_no_full;
    (muted & ~hw_unmute & ~full_now & ~rx_clear) |=> ~full_now;
  endproperty
  a_mute_no_full: assert property (p_mute_no_full) else $error("flag set while muted");
  property p_idle_wake;
    (idle_wake & run & ~(wr_acc & hit_c2)) |=> (~muted & ~$rose(status_reg[asu_pkg::ST_IDL]));
  endproperty
  a_idle_wake: assert property (p_idle_wake) else $error("idle wake wrong");
  property p_addr_wake;
    (frame_end & addr_wake & run & ~full_now & ~(wr_acc & hit_c2)) |=> (~muted & full_now);
  endproperty
  a_addr_wake: assert property (p_addr_wake) else $error("address wake wrong");
  property p_parity_flag;
    (accept & par_bad & ~full_now & run) |=> status_reg[asu_pkg::ST_PAR];
  endproperty
  a_parity_flag: assert property (p_parity_flag) else $error("parity flag missed");
  property p_irq_gate;
    (req_vec == 5'h00) |=> ~irq_o;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");
  property p_halt_frozen;
    (halt_i & $past(halt_i)) |-> ($stable(status_reg) & ~irq_o);
  endproperty
  a_halt_frozen: assert property (p_halt_frozen) else $error("halt not frozen");
  // the seen flag stands for the open gap between the status read and the data read
  sequence s_clear_req;
    status_seen_reg ##0 rd_dat;
  endsequence
  property p_clear_seq;
    (s_clear_req ##0 (~accept & ~idle_evt & run)) |=> (status_reg[5:0] == 6'h00);
  endproperty
  a_clear_seq: assert property (p_clear_seq) else $error("clear sequence failed");
  property p_wait_exit;
    irq_o |-> wait_exit_o;
  endproperty
  a_wait_exit: assert property (p_wait_exit) else $error("wait exit missing");

endmodule : asu_core
`default_nettype wire

// ---- testbench/asu_remote_node.sv ----
`timescale 1ns/1ns
`default_nettype none
// far node on the shared line; the line idles high as if pulled up
module asu_remote_node (
  input  wire logic clk_i,
  output logic      line_o
);
  initial line_o = 1'b1;
  // noisy picks a bit (0 = start) inverted for one tick near samples 8-10; out of range for none
  task automatic send(input logic [8:0] word, input int nbits, input int bclk, input int noisy);
    logic v;
    @(posedge clk_i);
    for (int i = 0; i < nbits + 2; i++) begin
      v = (i == 0) ? 1'b0 : (i > nbits) ? 1'b1 : word[i-1];
      line_o <= v;
      repeat (bclk / 2) @(posedge clk_i);
      if (i == noisy) line_o <= ~v;
      repeat (bclk / 16) @(posedge clk_i);
      line_o <= v;
      repeat (bclk - bclk / 2 - bclk / 16) @(posedge clk_i);
    end
  endtask : send
endmodule : asu_remote_node
`default_nettype wire

// ---- testbench/uart_mute_parity_sampling_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module uart_mute_parity_sampling_tb;
  // divider 3 gives four clocks per tick, so one bit is 64 clocks
  localparam int BCLK = 64;
  localparam logic [7:0] ST_A = asu_pkg::STATUS_OFS;
  localparam logic [7:0] DT_A = asu_pkg::DATA_OFS;
  localparam logic [7:0] C1_A = asu_pkg::CTRL_ONE_OFS;
  localparam logic [7:0] C2_A = asu_pkg::CTRL_TWO_OFS;
  typedef struct packed {
    logic [7:0] c1;
    logic [8:0] word;
    logic [3:0] nb;
    logic [3:0] noisy;
    logic [8:0] mask;
    logic [7:0] st;
  } asu_row_s;
  logic        clk, rst_n, psel, penable, pwrite, halt, tx_busy, tx_done;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd_q;
  logic        pready, pslverr, rd_e, irq, wait_exit, tx_load, line;
  logic [8:0]  tx_word, last_tx;
  int          fails, total_checks;
  asu_row_s    rows [8];
  logic [7:0]  tx_en [3] = '{8'h84, 8'h44, 8'h04};
  logic [7:0]  tx_c1 [4] = '{8'h04, 8'h06, 8'h14, 8'h00};
  logic [8:0]  tx_in [4] = '{9'h0b5, 9'h0b5, 9'h007, 9'h0a5};
  logic [8:0]  tx_ex [4] = '{9'h035, 9'h0b5, 9'h107, 9'h0a5};

  asu_core dut (.clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .rx_pin_i(line), .halt_i(halt),
    .tx_busy_i(tx_busy), .tx_done_i(tx_done), .tx_word_o(tx_word), .tx_load_o(tx_load),
    .irq_o(irq), .wait_exit_o(wait_exit));
  asu_remote_node u_rem (.clk_i(clk), .line_o(line));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // the load pulse is one cycle wide, so catch the word here
  always @(posedge clk) if (tx_load === 1'b1) last_tx <= tx_word;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : chk1
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) fails++;
    rd_q = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd_q, exp);
  endtask : rd_chk
  task automatic clr;
    apb(1'b0, ST_A, 32'h0);
    apb(1'b0, DT_A, 32'h0);
    repeat (3) @(posedge clk);
  endtask : clr
  task automatic rx(input logic [8:0] w, input int nb, input int noisy);
    u_rem.send(w, nb, BCLK, noisy);
    repeat (BCLK) @(posedge clk);
  endtask : rx

  initial begin
    #800_000;
    fails++;
    final_report;
  end

  initial begin
    {psel, penable, pwrite, halt, tx_busy, tx_done} = '0;
    paddr = '0;
    pwdata = '0;
    last_tx = '0;
    fails = 0;
    total_checks = 0;
    rst_n = 1'b0;
    rows[0] = '{8'h00, 9'h0a5, 4'd8, 4'hf, 9'h0ff, 8'he0};
    rows[1] = '{8'h10, 9'h15a, 4'd9, 4'hf, 9'h1ff, 8'he0};
    rows[2] = '{8'h04, 9'h035, 4'd8, 4'hf, 9'h07f, 8'he0};
    rows[3] = '{8'h06, 9'h035, 4'd8, 4'hf, 9'h07f, 8'he1};
    rows[4] = '{8'h14, 9'h135, 4'd9, 4'hf, 9'h0ff, 8'he1};
    rows[5] = '{8'h16, 9'h007, 4'd9, 4'hf, 9'h0ff, 8'he0};
    rows[6] = '{8'h00, 9'h00f, 4'd8, 4'h3, 9'h0ff, 8'he4};
    rows[7] = '{8'h00, 9'h0f0, 4'd8, 4'h0, 9'h0ff, 8'he4};
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    chk1(irq, 1'b0);
    rd_chk(ST_A, 32'hc0);
    apb(1'b1, ST_A, 32'h00);
    rd_chk(ST_A, 32'hc0);
    rd_chk(8'h20, 32'h0);
    chk1(rd_e, 1'b1);
    $display("test reset done");
    apb(1'b1, asu_pkg::DIVIDER_OFS, 32'h3);
    apb(1'b1, C2_A, 32'h04);
    foreach (rows[i]) begin
      apb(1'b1, C1_A, {24'h0, rows[i].c1});
      rx(rows[i].word, int'(rows[i].nb), int'(rows[i].noisy));
      rd_chk(ST_A, {24'h0, rows[i].st});
      apb(1'b0, DT_A, 32'h0);
      chk(rd_q & {23'h0, rows[i].mask}, {23'h0, rows[i].word & rows[i].mask});
      rd_chk(ST_A, 32'hc0);
    end
    $display("test table done");
    apb(1'b1, C1_A, 32'h00);
    apb(1'b1, C2_A, 32'h24);
    rx(9'h055, 8, 15);
    rx(9'h0aa, 8, 15);
    chk1(irq, 1'b1);
    chk1(wait_exit, 1'b1);
    rd_chk(ST_A, 32'he8);
    rd_chk(DT_A, 32'h055);
    repeat (3) @(posedge clk);
    chk1(irq, 1'b0);
    apb(1'b1, C1_A, 32'h05);
    apb(1'b1, C2_A, 32'h04);
    rx(9'h0b5, 8, 15);
    chk1(irq, 1'b1);
    clr();
    chk1(irq, 1'b0);
    foreach (tx_en[k]) begin
      apb(1'b1, C2_A, {24'h0, tx_en[k]});
      repeat (3) @(posedge clk);
      chk1(irq, k < 2);
    end
    apb(1'b1, C1_A, 32'h00);
    apb(1'b1, C2_A, 32'h14);
    rx(9'h011, 8, 15);
    clr();
    repeat (12 * BCLK) @(posedge clk);
    chk1(irq, 1'b1);
    rd_chk(ST_A, 32'hd0);
    clr();
    $display("test irq done");
    apb(1'b1, C1_A, 32'h08);
    apb(1'b1, C2_A, 32'h26);
    // control two is left alone while muted
    rx(9'h012, 8, 15);
    chk1(irq, 1'b0);
    rd_chk(ST_A, 32'hc0);
    rx(9'h092, 8, 15);
    chk1(irq, 1'b1);
    rd_chk(ST_A, 32'he0);
    rd_chk(DT_A, 32'h092);
    rd_chk(C2_A, 32'h24);
    apb(1'b1, C1_A, 32'h00);
    apb(1'b1, C2_A, 32'h06);
    repeat (12 * BCLK) @(posedge clk);
    rd_chk(C2_A, 32'h04);
    rd_chk(ST_A, 32'hc0);
    $display("test mute done");
    apb(1'b1, C2_A, 32'h84);
    halt <= 1'b1;
    repeat (3) @(posedge clk);
    chk1(irq, 1'b0);
    rx(9'h033, 8, 15);
    halt <= 1'b0;
    rd_chk(ST_A, 32'hc0);
    $display("test halt done");
    apb(1'b1, C2_A, 32'h0c);
    foreach (tx_c1[k]) begin
      apb(1'b1, C1_A, {24'h0, tx_c1[k]});
      apb(1'b1, DT_A, {23'h0, tx_in[k]});
      repeat (4) @(posedge clk);
      chk({23'h0, last_tx & (tx_c1[k][4] ? 9'h1ff : 9'h0ff)}, {23'h0, tx_ex[k]});
    end
    $display("test tx parity done");
    apb(1'b1, C2_A, 32'hc8);
    clr();
    tx_busy <= 1'b1;
    apb(1'b0, ST_A, 32'h0);
    apb(1'b1, DT_A, 32'h0);
    rd_chk(ST_A, 32'h00);
    chk1(irq, 1'b0);
    @(posedge clk);
    tx_done <= 1'b1;
    @(posedge clk);
    tx_done <= 1'b0;
    repeat (3) @(posedge clk);
    chk1(irq, 1'b1);
    tx_busy <= 1'b0;
    rd_chk(ST_A, 32'hc0);
    $display("test tx flags done");
    final_report;
  end
endmodule : uart_mute_parity_sampling_tb
`default_nettype wire
